//--- src/lge_consts.vh
`ifndef LGE_CONSTS_VH
`define LGE_CONSTS_VH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define LGE_IDX_DRV0        10'h0f0
`define LGE_IDX_DRV11       10'h0fb
`define LGE_IDX_GATE_LO     10'h0fc
`define LGE_IDX_GATE_HI     10'h0fd
`define LGE_IDX_CHAN_PD     10'h100
`define LGE_IDX_STATUS      10'h101

// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define LGE_DRV_PD_BIT      0
`define LGE_GATE_HI_MASK    8'h0f
`define LGE_CHAN_PD_MASK    4'hf
`define LGE_STATUS_LOCK_BIT 12
`define LGE_NUM_OUTPUTS     12
`define LGE_OUTS_PER_CHAN   3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LGE_DRV_RESET       8'h02
`define LGE_GATE_LO_RESET   8'h00
`define LGE_GATE_HI_RESET   8'h00
`define LGE_CHAN_PD_RESET   4'h0

`endif

//--- src/lge_gate.v
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// One output's enable: lock gating combined with power-downs
// ---------------------------------------------------------------
module lge_gate
(
	input  wire gate_en,
	input  wire lock_ind,
	input  wire drv_pd,
	input  wire chan_pd,
	output wire out_en
);

	wire lock_ok;

	// Gating off: lock level has no say; on: lock low forces down
	assign lock_ok = ~gate_en | lock_ind;

	// Any power-down setting overrides a good lock
	assign out_en = lock_ok & ~drv_pd & ~chan_pd;

endmodule

`default_nettype wire

//--- src/lge_top.v
// Operation
// - Output eleven control uses the output zero driver layout.
// - Gating bit zero, the reset default, leaves enable independent of lock.
// - Gating bit one: lock low powers output down, high enables it.
// - Low gating register bit n gates output n, outputs zero to seven.
// - High gating register bits zero to three gate outputs eight to eleven.
`timescale 1ns/100ps
`default_nettype none
`include "lge_consts.vh"

module lge_top
(
	input  wire        clk,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        current_source_lock_indication,
	output wire [11:0] out_enable,
	output wire [95:0] driver_ctrl
);

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	reg  [7:0]  drv_reg [0:11];
	reg  [7:0]  gate_lo_reg;
	reg  [3:0]  gate_hi_reg;
	reg  [3:0]  chan_pd_reg;
	reg  [31:0] rdata_reg;
	reg  [31:0] rdata_next;
	reg         lock_meta_reg;
	reg         lock_sync_reg;

	wire [9:0]  idx;
	wire        aligned;
	wire        hit_drv;
	wire        hit_gate_lo;
	wire        hit_gate_hi;
	wire        hit_chan_pd;
	wire        hit_status;
	wire        mapped;
	wire        setup_ph;
	wire        access_ph;
	wire        wr_en;
	wire [3:0]  drv_sel;
	wire        wr_drv;
	wire        wr_gate_lo;
	wire        wr_gate_hi;
	wire        wr_chan_pd;
	wire [11:0] gate_vec;
	wire [11:0] drv_pd_vec;
	wire [11:0] chan_pd_vec;
	wire [11:0] status_en;

	integer i;

	// ---------------------------------------------------------------
	// Local constants
	// ---------------------------------------------------------------
	// Only the low nibble of the upper gating register is stored
	localparam [7:0] GATE_HI_RST = `LGE_GATE_HI_RESET;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	assign idx         = paddr[11:2];
	assign aligned     = (paddr[1:0] == 2'b00);
	assign hit_drv     = aligned & (idx >= `LGE_IDX_DRV0) &
	                     (idx <= `LGE_IDX_DRV11);
	assign hit_gate_lo = aligned & (idx == `LGE_IDX_GATE_LO);
	assign hit_gate_hi = aligned & (idx == `LGE_IDX_GATE_HI);
	assign hit_chan_pd = aligned & (idx == `LGE_IDX_CHAN_PD);
	assign hit_status  = aligned & (idx == `LGE_IDX_STATUS);
	assign mapped      = hit_drv | hit_gate_lo | hit_gate_hi |
	                     hit_chan_pd | hit_status;
	// Driver indices run 0x0f0..0x0fb, so the low nibble is the output
	assign drv_sel     = idx[3:0];

	// ---------------------------------------------------------------
	// Bus handshake and write strobes
	// ---------------------------------------------------------------
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign wr_en     = access_ph & pwrite & mapped;

	// Status and unmapped slots never raise a strobe, so writes there
	// are dropped without touching any register
	assign wr_drv     = wr_en & hit_drv;
	assign wr_gate_lo = wr_en & hit_gate_lo;
	assign wr_gate_hi = wr_en & hit_gate_hi;
	assign wr_chan_pd = wr_en & hit_chan_pd;

	// Zero wait states: read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~mapped;
	assign prdata  = rdata_reg;

	// ---------------------------------------------------------------
	// Lock synchroniser for the status readback only
	// ---------------------------------------------------------------
	// The gating itself stays asynchronous; only the readback path is
	// clocked, so it needs a clean copy of the lock level.
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lock_meta_reg <= 1'b0;
			lock_sync_reg <= 1'b0;
		end
		else
		begin
			lock_meta_reg <= current_source_lock_indication;
			lock_sync_reg <= lock_meta_reg;
		end
	end

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (i = 0; i < `LGE_NUM_OUTPUTS; i = i + 1)
				drv_reg[i] <= `LGE_DRV_RESET;
			gate_lo_reg <= `LGE_GATE_LO_RESET;
			gate_hi_reg <= GATE_HI_RST[3:0];
			chan_pd_reg <= `LGE_CHAN_PD_RESET;
		end
		else
		begin
			if (wr_drv)
				drv_reg[drv_sel] <= pwdata[7:0];
			if (wr_gate_lo)
				gate_lo_reg <= pwdata[7:0];
			if (wr_gate_hi)
				gate_hi_reg <= pwdata[3:0];
			if (wr_chan_pd)
				chan_pd_reg <= pwdata[3:0] & `LGE_CHAN_PD_MASK;
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	always @*
	begin
		rdata_next = 32'h0000_0000;
		if (hit_drv)
			rdata_next = {24'h00_0000, drv_reg[drv_sel]};
		else if (hit_gate_lo)
			rdata_next = {24'h00_0000, gate_lo_reg};
		else if (hit_gate_hi)
			// Upper nibble is reserved and reads zero
			rdata_next = {24'h00_0000,
			              {4'h0, gate_hi_reg} & `LGE_GATE_HI_MASK};
		else if (hit_chan_pd)
			rdata_next = {28'h000_0000, chan_pd_reg};
		else if (hit_status)
			rdata_next = {19'h0_0000, lock_sync_reg, status_en};
	end

	// ---------------------------------------------------------------
	// Read data register
	// ---------------------------------------------------------------
	// Loaded in the setup cycle so prdata stands for the whole access
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_reg <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
			rdata_reg <= rdata_next;
	end

	// ---------------------------------------------------------------
	// Per-output gating
	// ---------------------------------------------------------------
	// Bit n of the low register gates output n, high register bit k
	// gates output eight plus k.
	assign gate_vec = {gate_hi_reg, gate_lo_reg};

	genvar n;
	generate
		for (n = 0; n < `LGE_NUM_OUTPUTS; n = n + 1)
		begin : g_out
			// Channel g powers down the three outputs 3g to 3g+2
			assign drv_pd_vec[n]  = drv_reg[n][`LGE_DRV_PD_BIT];
			assign chan_pd_vec[n] = chan_pd_reg[n / `LGE_OUTS_PER_CHAN];

			// Output gate on the raw lock level: no clock in the path
			lge_gate u_gate
			(
				.gate_en  (gate_vec[n]),
				.lock_ind (current_source_lock_indication),
				.drv_pd   (drv_pd_vec[n]),
				.chan_pd  (chan_pd_vec[n]),
				.out_en   (out_enable[n])
			);

			// Same decision on the synchronised lock for readback
			lge_gate u_stat
			(
				.gate_en  (gate_vec[n]),
				.lock_ind (lock_sync_reg),
				.drv_pd   (drv_pd_vec[n]),
				.chan_pd  (chan_pd_vec[n]),
				.out_en   (status_en[n])
			);

			// Output eleven gets its settings in the same layout
			assign driver_ctrl[n*8 +: 8] = drv_reg[n];
		end
	endgenerate

endmodule

`default_nettype wire

//--- tb/lge_props.sv
`timescale 1ns/100ps
`default_nettype none
module lge_props
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        current_source_lock_indication,
	input wire logic [11:0] out_enable,
	input wire logic [95:0] driver_ctrl
);
	logic [11:0] gate_reg;
	logic [3:0]  cpd_reg;
	logic [11:0] pd_v;
	logic [11:0] ex;
	wire         wr = psel & penable & pwrite & pready & ~|paddr[1:0];
	wire         lk = current_source_lock_indication;
	// Shadow of the gating and channel power-down registers
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			gate_reg <= 12'h000;
			cpd_reg <= 4'h0;
		end
		else if (wr)
			case (paddr[11:2])
				10'h0fc: gate_reg[7:0] <= pwdata[7:0];
				10'h0fd: gate_reg[11:8] <= pwdata[3:0];
				10'h100: cpd_reg <= pwdata[3:0];
				default: ;
			endcase
	always_comb
		for (int n = 0; n < 12; n++)
		begin
			pd_v[n] = driver_ctrl[8*n];
			ex[n] = (~gate_reg[n] | lk) & ~pd_v[n] & ~cpd_reg[n/3];
		end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_wr11;
		wr && paddr[11:2] == 10'h0fb;
	endsequence
	property p_ungated;
		((out_enable ^ ex) & ~gate_reg) == 12'h000;
	endproperty
	property p_gated_low;
		!lk |-> (out_enable & gate_reg) == 12'h000;
	endproperty
	property p_gated_high;
		lk |-> ((out_enable ^ ex) & gate_reg) == 12'h000;
	endproperty
	property p_low_map;
		((out_enable ^ ex) & 12'h0ff) == 12'h000;
	endproperty
	property p_high_map;
		((out_enable ^ ex) & 12'hf00) == 12'h000;
	endproperty
	property p_pd;
		(out_enable & pd_v) == 12'h000;
	endproperty
	property p_ctl11;
		s_wr11 |=> driver_ctrl[95:88] == $past(pwdata[7:0]);
	endproperty
	a_ungated: assert property (p_ungated) else $error("ungated bad");
	a_gated_low: assert property (p_gated_low) else $error("not off");
	a_gated_high: assert property (p_gated_high) else $error("not on");
	a_low_map: assert property (p_low_map) else $error("low map");
	a_high_map: assert property (p_high_map) else $error("high map");
	a_pd: assert property (p_pd) else $error("pd ignored");
	a_ctl11: assert property (p_ctl11) else $error("ctl11 bad");
endmodule
bind lge_top lge_props u_props (.clk(clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .out_enable(out_enable), .driver_ctrl(driver_ctrl),
	.current_source_lock_indication(current_source_lock_indication));
`default_nettype wire

//--- tb/lge_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lge_tb_top;
	logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, lk = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er;
	logic [11:0] out_enable;
	logic [95:0] driver_ctrl;
	integer      miscompares = 0, comparisons = 0;
	lge_top u_lge_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .out_enable(out_enable),
		.current_source_lock_indication(lk), .driver_ctrl(driver_ctrl));
	always #20 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Index times four gives the byte address
	task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
		integer n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) @(posedge clk) n++;
		if (n >= 50) miscompares++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Lock level stands for the current-source detector output with the
	// pin comparator enabled, as software must configure it
	task set_lock(input logic v);
		lk <= v;
		@(posedge clk);
	endtask
	task t_reset;
		apb(0, 10'h0fb, 0);
		chk(rd, 32'h02);
		apb(0, 10'h0fd, 0);
		chk(rd, 32'h0);
		set_lock(1);
		chk(out_enable, 12'hfff);
		set_lock(0);
		chk(out_enable, 12'hfff);
		$display("test reset done");
	endtask
	task t_gate;
		apb(1, 10'h0fc, 32'h81);
		apb(1, 10'h0fd, 32'hf8);
		apb(0, 10'h0fd, 0);
		chk(rd, 32'h08);
		set_lock(0);
		chk(out_enable, 12'h77e);
		set_lock(1);
		chk(out_enable, 12'hfff);
		apb(1, 10'h0fc, 32'h0);
		apb(1, 10'h0fd, 32'h0);
		$display("test gate done");
	endtask
	task t_pd;
		apb(1, 10'h0fb, 32'ha5);
		chk(driver_ctrl[95:88], 32'ha5);
		apb(0, 10'h0fb, 0);
		chk(rd, 32'ha5);
		apb(1, 10'h100, 32'h2);
		chk(out_enable, 12'h7c7);
		apb(0, 10'h100, 0);
		chk(rd, 32'h2);
		apb(1, 10'h0fc, 32'h01);
		set_lock(0);
		chk(out_enable, 12'h7c6);
		apb(0, 10'h3ff, 0);
		chk(er, 1'b1);
		apb(0, 10'h101, 0);
		chk(rd, 32'h0000_07c6);
		set_lock(1);
		chk(out_enable, 12'h7c7);
		@(posedge clk);
		apb(0, 10'h101, 0);
		chk(rd, 32'h0000_17c7);
		$display("test power-down done");
	endtask
	task summarize;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		summarize;
	end
	initial
	begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset;
		t_gate;
		t_pd;
		summarize;
	end
endmodule
`default_nettype wire
